// ---- verilog/ext_access_regs.svh ----
// register offsets, field positions, reset values and timing counts of the extended access engine
`ifndef EXT_ACCESS_REGS_SVH
`define EXT_ACCESS_REGS_SVH

// direct serial byte addresses
`define EWA_HI_ADDR 6'h02
`define EWA_LO_ADDR 6'h03
`define EWD_B0_ADDR 6'h04
`define EWD_B1_ADDR 6'h05
`define EWD_B2_ADDR 6'h06
`define EWD_B3_ADDR 6'h07
`define EXT_WRITE_CONTROL_STATUS_HI_ADDR 6'h08
`define EXT_WRITE_CONTROL_STATUS_LO_ADDR 6'h09
`define ERA_HI_ADDR 6'h0a
`define ERA_LO_ADDR 6'h0b
`define EXT_READ_CONTROL_STATUS_HI_ADDR 6'h0c
`define EXT_READ_CONTROL_STATUS_LO_ADDR 6'h0d
`define EXT_READ_DATA_HIGH_HI_ADDR 6'h0e
`define EXT_READ_DATA_HIGH_LO_ADDR 6'h0f
`define EXT_READ_DATA_LOW_HI_ADDR 6'h10
`define EXT_READ_DATA_LOW_LO_ADDR 6'h11
`define CTRL_HI_ADDR 6'h1e
`define CTRL_LO_ADDR 6'h1f
`define ERR_HI_ADDR 6'h24
`define ERR_LO_ADDR 6'h25
`define WARN_HI_ADDR 6'h26
`define WARN_LO_ADDR 6'h27
`define KEY_HI_ADDR 6'h3c
`define KEY_LO_ADDR 6'h3d

// field positions inside the addressed byte
`define START_BIT 7
`define PROGRESS_BIT 0
`define DONE_BIT 0
`define CTRL_SPECIAL_MSB 7
`define CTRL_SPECIAL_LSB 4
`define CTRL_CLE_BIT 0
`define CTRL_CLW_BIT 1
`define ERR_XEE_BIT 2
`define ERR_EUE_BIT 5
`define WARN_XEE_BIT 7
`define WARN_ESE_BIT 5
`define WARN_BSY_BIT 2
`define KEY_UNLOCKED_BIT 0

// fixed upper nibbles of the status words
`define ERR_TAG 4'ha
`define WARN_TAG 4'hb

// command and code values
`define START_CODE 8'h80
`define SPECIAL_NONE 4'h0
`define SPECIAL_MARGIN_LOW 4'h1
`define SPECIAL_MARGIN_HIGH 4'h2
`define SHADOW_OFFSET 8'h40
`define KEY_SEQ_LEN 3'd5
`define KEY_BYTE0 8'h00
`define KEY_BYTE1 8'h27
`define KEY_BYTE2 8'h81
`define KEY_BYTE3 8'h1f
`define KEY_BYTE4 8'h77

// reset values
`define ADDR_RESET 8'h00
`define DATA_RESET 32'h0000_0000

// timing
`define CLK_PERIOD_NS 40
`define NV_READ_TIME_US 2
`define NV_READ_CYCLES ((`NV_READ_TIME_US * 1000) / `CLK_PERIOD_NS)
`define NV_WRITE_TIME_MS 24
`define NV_WRITE_CYCLES ((`NV_WRITE_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// ---- verilog/ext_access_pkg.sv ----
// types and the check-code function shared by the extended access engine and its store
package ext_access_pkg;

  typedef enum logic [1:0] {
    eng_idle,
    eng_shadow,
    eng_nvm
  } eng_state_e;

  typedef enum logic [1:0] {
    st_idle,
    st_run,
    st_done
  } store_state_e;

  // six check bits, each the parity of every sixth data bit
  function automatic logic [5:0] check_code(input logic [23:0] data);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < 24; i++) begin
      c[i % 6] = c[i % 6] ^ data[i];
    end
    return c;
  endfunction

endpackage

// ---- verilog/nvm_store.sv ----
// non-volatile word array with timed read and program cycles
`timescale 1ns/1ns
`include "ext_access_regs.svh"
module nvm_store #(
  parameter int WRITE_CYCLES = `NV_WRITE_CYCLES,
  parameter int READ_CYCLES = `NV_READ_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic req_valid, // one-cycle request
  input wire logic req_write, // 1 program, 0 read
  input wire logic [5:0] req_addr, // word address
  input wire logic [23:0] req_wdata, // configuration content
  input wire logic abort, // program abort level
  output logic done, // one-cycle completion pulse
  output logic aborted, // program aborted, valid with done
  output logic [31:0] rdata // stored word, valid with done
);

  // the counter must hold the longer of the two loads, or a short program time truncates the read count
  localparam int CW = $clog2((WRITE_CYCLES > READ_CYCLES ? WRITE_CYCLES : READ_CYCLES) + 1);

  logic [31:0] cells [0:63];
  ext_access_pkg::store_state_e state_q;
  logic [CW-1:0] count_q;
  logic write_q;
  logic [5:0] addr_q;
  logic [23:0] wdata_q;
  logic abort_seen_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ext_access_pkg::st_idle;
      count_q <= '0;
      write_q <= 1'b0;
      addr_q <= 6'h00;
      wdata_q <= 24'h000000;
    end else begin
      case (state_q)
        ext_access_pkg::st_idle: begin
          if (req_valid) begin
            state_q <= ext_access_pkg::st_run;
            write_q <= req_write;
            addr_q <= req_addr;
            wdata_q <= req_wdata;
            count_q <= req_write ? CW'(WRITE_CYCLES - 1) : CW'(READ_CYCLES - 1);
          end
        end
        ext_access_pkg::st_run: begin
          if (count_q == '0 || (write_q && abort)) begin
            state_q <= ext_access_pkg::st_done;
          end else begin
            count_q <= count_q - CW'(1);
          end
        end
        default: begin
          state_q <= ext_access_pkg::st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      abort_seen_q <= 1'b0;
    end else if (state_q == ext_access_pkg::st_idle) begin
      abort_seen_q <= 1'b0;
    end else if (state_q == ext_access_pkg::st_run && write_q && abort) begin
      abort_seen_q <= 1'b1;
    end
  end

  // an aborted program leaves the old word untouched
  always_ff @(posedge clk) begin
    if (state_q == ext_access_pkg::st_done && write_q && !abort_seen_q) begin
      cells[addr_q] <= {ext_access_pkg::check_code(wdata_q), 2'b00, wdata_q};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done <= 1'b0;
      aborted <= 1'b0;
      rdata <= `DATA_RESET;
    end else begin
      done <= (state_q == ext_access_pkg::st_done);
      aborted <= (state_q == ext_access_pkg::st_done) && write_q && abort_seen_q;
      if (state_q == ext_access_pkg::st_done && !write_q) begin
        rdata <= cells[addr_q];
      end
    end
  end

endmodule

// ---- verilog/ext_access.sv ----
// indirect access engine for non-volatile configuration memory and its shadow copy
`timescale 1ns/1ns
`include "ext_access_regs.svh"
module ext_access #(
  parameter int WRITE_CYCLES = `NV_WRITE_CYCLES, // program time in cycles
  parameter logic [23:0] SHADOW_USED_MASK = 24'hff_ffff // content bits that exist in shadow
) (
  input wire logic clk, // system clock, 25 MHz
  input wire logic rstn, // async reset, active low
  input wire logic reg_wr, // byte write strobe
  input wire logic reg_rd, // byte read strobe
  input wire logic [5:0] reg_addr, // direct byte address
  input wire logic [7:0] reg_wdata, // write byte
  output logic [7:0] reg_rdata, // read byte, one cycle after reg_rd
  input wire logic program_abort_pin, // asynchronous program abort
  output logic [1:0] sense_threshold // 0 normal, 1 low, 2 high
);

  // host-visible registers
  logic [7:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [7:0] rd_addr_q;
  logic [31:0] rd_data_q;
  logic [3:0] special_q;
  logic wr_pend_q, rd_pend_q;
  logic wr_done_q, rd_done_q;
  logic warn_xee_q, warn_ese_q, err_xee_q, err_eue_q;
  logic [2:0] key_idx_q;
  logic unlocked_q;

  // engine
  ext_access_pkg::eng_state_e state_q;
  logic op_write_q;
  logic [7:0] op_addr_q;
  logic [23:0] shadow_q [0:63];
  logic abort_meta_q, abort_sync_q;
  logic store_req;
  logic store_done, store_aborted;
  logic [31:0] store_rdata;

  // decoded host actions
  logic wr_start, rd_start, clear_warn, clear_err;
  logic idle, take_write, take_read;
  logic finish_write, finish_read, violation;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
    return reg_wr && (a == b);
  endfunction

  function automatic logic [7:0] key_byte(input logic [2:0] idx);
    logic [7:0] k;
    k = `KEY_BYTE0;
    case (idx)
      3'd1: k = `KEY_BYTE1;
      3'd2: k = `KEY_BYTE2;
      3'd3: k = `KEY_BYTE3;
      3'd4: k = `KEY_BYTE4;
      default: k = `KEY_BYTE0;
    endcase
    return k;
  endfunction

  // a start while the same kind is pending or running is ignored
  assign wr_start = hit(reg_addr, `EXT_WRITE_CONTROL_STATUS_HI_ADDR) && reg_wdata == `START_CODE && !wr_pend_q;
  assign rd_start = hit(reg_addr, `EXT_READ_CONTROL_STATUS_HI_ADDR) && reg_wdata == `START_CODE && !rd_pend_q;
  assign clear_warn = hit(reg_addr, `CTRL_HI_ADDR) && reg_wdata[`CTRL_CLW_BIT];
  assign clear_err = hit(reg_addr, `CTRL_HI_ADDR) && reg_wdata[`CTRL_CLE_BIT];

  assign idle = (state_q == ext_access_pkg::eng_idle);
  assign take_write = idle && wr_pend_q;
  assign take_read = idle && rd_pend_q && !wr_pend_q;
  // programming the array needs the key; shadow and reads do not
  assign violation = take_write && !wr_addr_q[6] && !unlocked_q;
  assign store_req = (take_write && !wr_addr_q[6] && unlocked_q) || (take_read && !rd_addr_q[6]);
  assign finish_write = violation || (op_write_q &&
    ((state_q == ext_access_pkg::eng_shadow) || (state_q == ext_access_pkg::eng_nvm && store_done)));
  assign finish_read = !op_write_q &&
    ((state_q == ext_access_pkg::eng_shadow) || (state_q == ext_access_pkg::eng_nvm && store_done));

  // abort pin comes from outside the clock domain
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      abort_meta_q <= 1'b0;
      abort_sync_q <= 1'b0;
    end else begin
      abort_meta_q <= program_abort_pin;
      abort_sync_q <= abort_meta_q;
    end
  end

  // address and data bytes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_addr_q <= `ADDR_RESET;
      rd_addr_q <= `ADDR_RESET;
      wr_data_q <= `DATA_RESET;
    end else begin
      if (hit(reg_addr, `EWA_LO_ADDR)) wr_addr_q <= reg_wdata;
      if (hit(reg_addr, `ERA_LO_ADDR)) rd_addr_q <= reg_wdata;
      if (hit(reg_addr, `EWD_B0_ADDR)) wr_data_q[31:24] <= reg_wdata;
      if (hit(reg_addr, `EWD_B1_ADDR)) wr_data_q[23:16] <= reg_wdata;
      if (hit(reg_addr, `EWD_B2_ADDR)) wr_data_q[15:8] <= reg_wdata;
      if (hit(reg_addr, `EWD_B3_ADDR)) wr_data_q[7:0] <= reg_wdata;
    end
  end

  // pending starts; a pending start holds until the engine finishes it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      if (wr_start) wr_pend_q <= 1'b1;
      else if (finish_write) wr_pend_q <= 1'b0;
      if (rd_start) rd_pend_q <= 1'b1;
      else if (finish_read) rd_pend_q <= 1'b0;
    end
  end

  // a start can never meet its own completion, since starts are ignored while pending
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_done_q <= 1'b0;
      rd_done_q <= 1'b0;
    end else begin
      if (wr_start) wr_done_q <= 1'b0;
      else if (finish_write) wr_done_q <= 1'b1;
      if (rd_start) rd_done_q <= 1'b0;
      else if (finish_read) rd_done_q <= 1'b1;
    end
  end

  // one engine serves both kinds; a pending write goes first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ext_access_pkg::eng_idle;
      op_write_q <= 1'b0;
      op_addr_q <= `ADDR_RESET;
    end else begin
      case (state_q)
        ext_access_pkg::eng_idle: begin
          if (take_write && !violation) begin
            op_write_q <= 1'b1;
            op_addr_q <= wr_addr_q;
            state_q <= wr_addr_q[6] ? ext_access_pkg::eng_shadow : ext_access_pkg::eng_nvm;
          end else if (take_read) begin
            op_write_q <= 1'b0;
            op_addr_q <= rd_addr_q;
            state_q <= rd_addr_q[6] ? ext_access_pkg::eng_shadow : ext_access_pkg::eng_nvm;
          end
        end
        ext_access_pkg::eng_shadow: begin
          state_q <= ext_access_pkg::eng_idle;
        end
        ext_access_pkg::eng_nvm: begin
          if (store_done) state_q <= ext_access_pkg::eng_idle;
        end
        default: begin
          state_q <= ext_access_pkg::eng_idle;
        end
      endcase
    end
  end

  // shadow copy keeps only the content bits that exist
  always_ff @(posedge clk) begin
    if (state_q == ext_access_pkg::eng_shadow && op_write_q) begin
      shadow_q[op_addr_q[5:0]] <= wr_data_q[23:0] & SHADOW_USED_MASK;
    end
  end

  // read result changes only at completion, so a polled done flag guards it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= `DATA_RESET;
    end else if (state_q == ext_access_pkg::eng_shadow && !op_write_q) begin
      rd_data_q <= {8'h00, shadow_q[op_addr_q[5:0]]};
    end else if (state_q == ext_access_pkg::eng_nvm && !op_write_q && store_done) begin
      rd_data_q <= store_rdata;
    end
  end

  // sticky warning and error bits; a new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      warn_xee_q <= 1'b0;
      warn_ese_q <= 1'b0;
      err_xee_q <= 1'b0;
      err_eue_q <= 1'b0;
    end else begin
      if (violation || (finish_write && store_aborted)) warn_xee_q <= 1'b1;
      else if (clear_warn) warn_xee_q <= 1'b0;
      if (finish_write && store_aborted) err_xee_q <= 1'b1;
      else if (clear_err) err_xee_q <= 1'b0;
      // one check-code mismatch is reported as a single error, more as uncorrectable
      if (finish_read && state_q == ext_access_pkg::eng_nvm && code_diff_cnt() == 3'd1) warn_ese_q <= 1'b1;
      else if (clear_warn) warn_ese_q <= 1'b0;
      if (finish_read && state_q == ext_access_pkg::eng_nvm && code_diff_cnt() > 3'd1) err_eue_q <= 1'b1;
      else if (clear_err) err_eue_q <= 1'b0;
    end
  end

  function automatic logic [2:0] code_diff_cnt();
    logic [5:0] diff;
    logic [2:0] n;
    diff = store_rdata[31:26] ^ ext_access_pkg::check_code(store_rdata[23:0]);
    n = 3'd0;
    for (int i = 0; i < 6; i++) begin
      n = n + {2'b00, diff[i]};
    end
    return n;
  endfunction

  // only the two margin codes stay in the special field; any other code clears it and reads back zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      special_q <= `SPECIAL_NONE;
    end else if (hit(reg_addr, `CTRL_HI_ADDR)) begin
      if (reg_wdata[`CTRL_SPECIAL_MSB:`CTRL_SPECIAL_LSB] == `SPECIAL_MARGIN_LOW ||
          reg_wdata[`CTRL_SPECIAL_MSB:`CTRL_SPECIAL_LSB] == `SPECIAL_MARGIN_HIGH) begin
        special_q <= reg_wdata[`CTRL_SPECIAL_MSB:`CTRL_SPECIAL_LSB];
      end else begin
        special_q <= `SPECIAL_NONE;
      end
    end
  end

  // the sense reference drives every array read while the code is held
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sense_threshold <= 2'd0;
    end else if (special_q == `SPECIAL_MARGIN_LOW) begin
      sense_threshold <= 2'd1;
    end else if (special_q == `SPECIAL_MARGIN_HIGH) begin
      sense_threshold <= 2'd2;
    end else begin
      sense_threshold <= 2'd0;
    end
  end

  // unlock key: a wrong byte restarts the sequence, and a zero byte counts as its first entry
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      key_idx_q <= 3'd0;
      unlocked_q <= 1'b0;
    end else if (hit(reg_addr, `KEY_HI_ADDR) && !unlocked_q) begin
      if (reg_wdata == key_byte(key_idx_q)) begin
        if (key_idx_q == `KEY_SEQ_LEN - 3'd1) unlocked_q <= 1'b1;
        key_idx_q <= key_idx_q + 3'd1;
      end else if (reg_wdata == `KEY_BYTE0) begin
        key_idx_q <= 3'd1;
      end else begin
        key_idx_q <= 3'd0;
      end
    end
  end

  // start, take and flag stages cost three cycles of each time budget
  nvm_store #(
    .WRITE_CYCLES(WRITE_CYCLES - 3),
    .READ_CYCLES(`NV_READ_CYCLES - 3)
  ) u_store (
    .clk(clk),
    .rstn(rstn),
    .req_valid(store_req),
    .req_write(take_write),
    .req_addr(take_write ? wr_addr_q[5:0] : rd_addr_q[5:0]),
    .req_wdata(wr_data_q[23:0]),
    .abort(abort_sync_q),
    .done(store_done),
    .aborted(store_aborted),
    .rdata(store_rdata)
  );

  // read-back byte, registered; start bits and clear bits read as zero
  // a read beside a same-cycle write returns the old byte, so commands may overlap data return
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `EWA_LO_ADDR) begin
        reg_rdata <= wr_addr_q;
      end else if (reg_addr == `EWD_B0_ADDR) begin
        reg_rdata <= wr_data_q[31:24];
      end else if (reg_addr == `EWD_B1_ADDR) begin
        reg_rdata <= wr_data_q[23:16];
      end else if (reg_addr == `EWD_B2_ADDR) begin
        reg_rdata <= wr_data_q[15:8];
      end else if (reg_addr == `EWD_B3_ADDR) begin
        reg_rdata <= wr_data_q[7:0];
      end else if (reg_addr == `EXT_WRITE_CONTROL_STATUS_HI_ADDR) begin
        reg_rdata <= {7'h00, wr_pend_q};
      end else if (reg_addr == `EXT_WRITE_CONTROL_STATUS_LO_ADDR) begin
        reg_rdata <= {7'h00, wr_done_q};
      end else if (reg_addr == `ERA_LO_ADDR) begin
        reg_rdata <= rd_addr_q;
      end else if (reg_addr == `EXT_READ_CONTROL_STATUS_HI_ADDR) begin
        reg_rdata <= {7'h00, rd_pend_q};
      end else if (reg_addr == `EXT_READ_CONTROL_STATUS_LO_ADDR) begin
        reg_rdata <= {7'h00, rd_done_q};
      end else if (reg_addr == `EXT_READ_DATA_HIGH_HI_ADDR) begin
        reg_rdata <= rd_data_q[31:24];
      end else if (reg_addr == `EXT_READ_DATA_HIGH_LO_ADDR) begin
        reg_rdata <= rd_data_q[23:16];
      end else if (reg_addr == `EXT_READ_DATA_LOW_HI_ADDR) begin
        reg_rdata <= rd_data_q[15:8];
      end else if (reg_addr == `EXT_READ_DATA_LOW_LO_ADDR) begin
        reg_rdata <= rd_data_q[7:0];
      end else if (reg_addr == `CTRL_HI_ADDR) begin
        reg_rdata <= {special_q, 4'h0};
      end else if (reg_addr == `ERR_HI_ADDR) begin
        reg_rdata <= {`ERR_TAG, 1'b0, err_xee_q, 2'b00};
      end else if (reg_addr == `ERR_LO_ADDR) begin
        reg_rdata <= {2'b00, err_eue_q, 5'h00};
      end else if (reg_addr == `WARN_HI_ADDR) begin
        reg_rdata <= {`WARN_TAG, 4'h0};
      end else if (reg_addr == `WARN_LO_ADDR) begin
        reg_rdata <= {warn_xee_q, 1'b0, warn_ese_q, 2'b00, !idle || wr_pend_q || rd_pend_q, 2'b00};
      end else if (reg_addr == `KEY_LO_ADDR) begin
        reg_rdata <= {7'h00, unlocked_q};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule

// ---- bench/host_model.sv ----
// host controller model that drives the direct byte register bus
`timescale 1ns/1ns
module host_model (
  input wire logic clk, // system clock
  output logic reg_wr, // byte write strobe
  output logic reg_rd, // byte read strobe
  output logic [5:0] reg_addr, // direct byte address
  output logic [7:0] reg_wdata, // write byte
  input wire logic [7:0] reg_rdata // read byte
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    // a released byte lane shows junk, not the last value
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  task automatic unlock;
    logic [39:0] key;
    key = 40'h00_27_81_1f_77;
    for (int i = 0; i < 5; i++) wr(6'h3c, key[39-8*i -: 8]);
  endtask

  task automatic ext_wr(input logic [7:0] ea, input logic [31:0] wd);
    wr(6'h03, ea);
    for (int i = 0; i < 4; i++) wr(6'(4 + i), wd[31-8*i -: 8]);
    wr(6'h08, 8'h80);
  endtask

  task automatic ext_rd(input logic [7:0] ea);
    wr(6'h0b, ea);
    wr(6'h0c, 8'h80);
  endtask

  // poll count is bounded so a dead engine cannot hang the run
  task automatic poll(input logic [5:0] a, output int n);
    logic [7:0] d;
    n = 0;
    d = 8'h00;
    while (d[0] !== 1'b1 && n < 2000) begin
      rd(a, d);
      n++;
    end
  endtask

  // only called once the done flag is seen, so the halves stay consistent
  task automatic fetch(output logic [31:0] w);
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      rd(6'(14 + i), d);
      w[31-8*i -: 8] = d;
    end
  endtask
endmodule

// ---- bench/ext_access_chk.sv ----
// port-level assertions for the extended access engine
`timescale 1ns/1ns
module ext_access_chk (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic reg_wr, // byte write strobe
  input wire logic reg_rd, // byte read strobe
  input wire logic [5:0] reg_addr, // direct byte address
  input wire logic [7:0] reg_wdata, // write byte
  input wire logic [7:0] reg_rdata, // read byte
  input wire logic [1:0] sense_threshold // array read threshold
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // a locked program ends at once, so only shadow writes are sure to show the cleared flag at the first poll
  logic wr_to_shadow_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_to_shadow_q <= 1'b0;
    end else if (reg_wr && reg_addr == 6'h03) begin
      wr_to_shadow_q <= reg_wdata[6];
    end
  end

  sequence s_start(a);
    reg_wr && reg_addr == a && reg_wdata == 8'h80;
  endsequence
  sequence s_poll(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_ctrl;
    reg_wr && reg_addr == 6'h1e;
  endsequence

  a_low_threshold: assert property (s_ctrl and reg_wdata[7:4] == 4'h1 |-> ##2 sense_threshold == 2'd1)
    else $error("lowered threshold not applied");
  a_high_threshold: assert property (s_ctrl and reg_wdata[7:4] == 4'h2 |-> ##2 sense_threshold == 2'd2)
    else $error("raised threshold not applied");
  a_normal_threshold: assert property (s_ctrl and reg_wdata[7:5] != 3'h0 && reg_wdata[7:4] != 4'h2
    or s_ctrl and reg_wdata[7:4] == 4'h0 |-> ##2 sense_threshold == 2'd0)
    else $error("threshold not returned to normal");
  a_threshold_held: assert property ($changed(sense_threshold) |-> $past(reg_wr && reg_addr == 6'h1e, 2))
    else $error("threshold moved without a control write");
  a_threshold_legal: assert property (sense_threshold != 2'd3)
    else $error("threshold code out of range");
  a_pad_zero: assert property (s_poll(6'h0e) |=> reg_rdata[1:0] == 2'b00)
    else $error("read data bits 25:24 not zero");
  a_wr_done_clear: assert property (s_start(6'h08) ##0 wr_to_shadow_q ##2 s_poll(6'h09) |=> !reg_rdata[0])
    else $error("write done not cleared by start");
  a_rd_done_clear: assert property (s_start(6'h0c) ##2 s_poll(6'h0d) |=> !reg_rdata[0])
    else $error("read done not cleared by start");
endmodule

bind ext_access ext_access_chk ext_access_chk_i (
  .clk(clk),
  .rstn(rstn),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .sense_threshold(sense_threshold)
);

// ---- bench/extended_access_tb.sv ----
// self-checking bench for the extended access engine
`timescale 1ns/1ns
module extended_memory_access_tb;
  localparam int WC = 20;
  localparam logic [23:0] MASK = 24'h0f_ffff;
  typedef struct {logic [7:0] ea; logic [31:0] wd; logic [31:0] exp;} row_s;
  logic clk;
  logic rstn;
  logic abort_pin;
  logic reg_wr;
  logic reg_rd;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [1:0] sense_threshold;
  logic [7:0] b;
  logic [31:0] w;
  int n;
  int bad_count = 0;
  int n_compared = 0;
  row_s rows[4];

  ext_access #(.WRITE_CYCLES(WC), .SHADOW_USED_MASK(MASK)) ext_access_i (
    .clk(clk),
    .rstn(rstn),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .program_abort_pin(abort_pin),
    .sense_threshold(sense_threshold)
  );
  host_model host_model_i (
    .clk(clk),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );

  function automatic logic [31:0] nv_word(input logic [31:0] d);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < 24; i++) c[i % 6] ^= d[i];
    return {c, 2'b00, d[23:0]};
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic xwrite(input logic [7:0] ea, input logic [31:0] wd);
    host_model_i.ext_wr(ea, wd);
    host_model_i.poll(6'h09, n);
    check("write polls", 32'h1, 32'(n <= (ea[6] ? 2 : WC / 2 + 1)));
  endtask

  task automatic xread(input logic [7:0] ea, input logic [31:0] exp);
    host_model_i.ext_rd(ea);
    host_model_i.poll(6'h0d, n);
    check("read polls", 32'h1, 32'(n <= (ea[6] ? 2 : 26)));
    host_model_i.fetch(w);
    check("read word", exp, w);
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict;
  end

  initial begin
    rstn = 1'b0;
    abort_pin = 1'b0;
    rows[0] = '{8'h45, 32'hffa4_5678, {8'h00, 24'ha45678 & MASK}};
    rows[1] = '{8'h7f, 32'h0000_0001, 32'h0000_0001};
    rows[2] = '{8'h1f, 32'h00a4_5678, nv_word(32'h00a4_5678)};
    rows[3] = '{8'h00, 32'hff00_0000, nv_word(32'hff00_0000)};
    repeat (12) @(posedge clk);
    #1 rstn = 1'b1;
    host_model_i.rd(6'h0d, b);
    check("done after reset", 32'h0, 32'(b));
    // programming before the key is an access violation
    xwrite(8'h10, 32'h0000_0055);
    host_model_i.rd(6'h27, b);
    check("locked warning", 32'h1, 32'(b[7]));
    host_model_i.wr(6'h1e, 8'h03);
    host_model_i.rd(6'h27, b);
    check("warning cleared", 32'h0, 32'(b[7]));
    host_model_i.unlock;
    host_model_i.rd(6'h3d, b);
    check("unlocked", 32'h1, 32'(b[0]));
    for (int i = 0; i < 4; i++) begin
      xwrite(rows[i].ea, rows[i].wd);
      xread(rows[i].ea, rows[i].exp);
    end
    // margin codes: set low, set high, illegal, cleared
    for (int i = 0; i < 4; i++) begin
      host_model_i.wr(6'h1e, {4'(16'h1230 >> (12 - 4 * i)), 4'h0});
      repeat (2) @(posedge clk);
      check("threshold", 32'(8'b01_10_00_00 >> (6 - 2 * i)) & 32'h3, 32'(sense_threshold));
      host_model_i.rd(6'h1e, b);
      check("special field", 32'(8'b01_10_00_00 >> (6 - 2 * i)) & 32'h3, 32'(b[7:4]));
      if (i < 2) xread(8'h1f, rows[2].exp);
    end
    // abort a program in flight
    host_model_i.ext_wr(8'h20, 32'h0000_0001);
    abort_pin = 1'b1;
    host_model_i.poll(6'h09, n);
    abort_pin = 1'b0;
    host_model_i.rd(6'h24, b);
    check("abort error", 32'h1, 32'(b[2]));
    host_model_i.rd(6'h27, b);
    check("abort warning", 32'h1, 32'(b[7]));
    print_verdict;
  end
endmodule
